// file: pkg/flash_pkg.sv
// shared constants for the parallel flash command controller
package flash_pkg;
  // ==========================================================
  // widths and clock
  localparam int AW = 22;
  localparam int DW = 16;
  localparam int CLK_MHZ = 250;
  // ==========================================================
  // apb register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ADDR = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  localparam logic [7:0] A_CMD = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_RDAT = 8'h14;
  // control bits
  localparam int C_BYTE = 0;
  localparam int C_ACCEL = 1;
  localparam int C_HWRST = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  // sticky status bits, write one to clear
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_REFUSED = 3;
  // ==========================================================
  // controller commands written to the command register
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_IDENT = 4'h2,
    OP_SEC_ENTER = 4'h3, OP_SEC_EXIT = 4'h4, OP_PROGRAM = 4'h5,
    OP_BYP_ENTER = 4'h6, OP_BYP_PROG = 4'h7, OP_BYP_EXIT = 4'h8,
    OP_CHIP = 4'h9, OP_SECT = 4'hA, OP_SECT_ADD = 4'hB,
    OP_SUSP = 4'hC, OP_RESUME = 4'hD
  } op_e;
  // ==========================================================
  // flash command data and unlock addresses
  localparam logic [7:0] D_UNL1 = 8'hAA;
  localparam logic [7:0] D_UNL2 = 8'h55;
  localparam logic [7:0] D_IDENT = 8'h90;
  localparam logic [7:0] D_SECENT = 8'h88;
  localparam logic [7:0] D_PROG = 8'hA0;
  localparam logic [7:0] D_BYPASS = 8'h20;
  localparam logic [7:0] D_ERASE = 8'h80;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SECT = 8'h30;
  localparam logic [7:0] D_SUSP = 8'hB0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_RESET = 8'hF0;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam logic [AW-1:0] U1_W = 22'h000555;
  localparam logic [AW-1:0] U2_W = 22'h0002AA;
  localparam logic [AW-1:0] U1_B = 22'h000AAA;
  localparam logic [AW-1:0] U2_B = 22'h000555;
  // status bit positions on the data bus
  localparam int DQ_POLL = 7;
  localparam int DQ_ERR = 5;
  // ==========================================================
  // timing
  localparam int T_STROBE_NS = 50;
  localparam int T_READ_NS = 90;
  localparam int WINDOW_US = 50;
  localparam int SUSP_US = 20;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int SUSP_CYC = SUSP_US * CLK_MHZ;
endpackage

// file: pkg/flash_bus_if.sv
// request and answer between the sequencer and the pin cycle engine
`timescale 1ns/1ps
interface flash_bus_if;
  logic req;
  logic wr;
  logic abort;
  logic ack;
  logic [flash_pkg::AW-1:0] addr;
  logic [flash_pkg::DW-1:0] wdata;
  logic [flash_pkg::DW-1:0] rdata;
  modport ctl(output req, wr, abort, addr, wdata, input ack, rdata);
  modport eng(input req, wr, abort, addr, wdata, output ack, rdata);
endinterface

// file: verilog/flash_cycle_engine.sv
// single asynchronous bus cycle generator for the flash pins
`timescale 1ns/1ps
module flash_cycle_engine #(
  parameter int STROBE_CYC = flash_pkg::STROBE_CYC,
  parameter int READ_CYC = flash_pkg::READ_CYC
) (
  input wire logic clk_sys_i,                       // system clock
  input wire logic rstn_i,                          // sync reset, low
  flash_bus_if.eng bus,                             // sequencer side
  output logic [flash_pkg::AW-1:0] fl_addr_o,       // address pins
  output logic [flash_pkg::DW-1:0] fl_dq_o,         // data out
  output logic fl_dq_oe_o,                          // data drive enable
  input wire logic [flash_pkg::DW-1:0] fl_dq_i,     // data in
  output logic fl_ce_n_o,                           // chip select
  output logic fl_we_n_o,                           // write strobe
  output logic fl_oe_n_o                            // read strobe
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_e;
  eng_e st_r;
  logic wr_r;
  logic ack_r;
  logic [7:0] cnt_r;
  logic [flash_pkg::DW-1:0] rdata_r;

  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;

  // ==========================================================
  // cycle sequencing
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || bus.abort) begin
      st_r <= E_IDLE;
      wr_r <= 1'b0;
      ack_r <= 1'b0;
      cnt_r <= 8'h00;
      rdata_r <= '0;
      fl_addr_o <= '0;
      fl_dq_o <= '0;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
    end else begin
      ack_r <= 1'b0;
      case (st_r)
        E_IDLE: if (bus.req) begin
          fl_addr_o <= bus.addr;
          fl_dq_o <= bus.wdata;
          fl_dq_oe_o <= bus.wr;
          wr_r <= bus.wr;
          fl_ce_n_o <= 1'b0;
          st_r <= E_SETUP;
        end
        E_SETUP: begin
          // address settles a full cycle before the strobe falls
          fl_we_n_o <= ~wr_r;
          fl_oe_n_o <= wr_r;
          cnt_r <= wr_r ? 8'(STROBE_CYC - 1) : 8'(READ_CYC - 1);
          st_r <= E_STROBE;
        end
        E_STROBE: if (cnt_r == 8'h00) begin
          fl_we_n_o <= 1'b1;
          fl_oe_n_o <= 1'b1;
          if (!wr_r) begin
            rdata_r <= fl_dq_i;
          end
          st_r <= E_HOLD;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        E_HOLD: begin
          // data held one cycle past the rising strobe edge
          fl_ce_n_o <= 1'b1;
          fl_dq_oe_o <= 1'b0;
          ack_r <= 1'b1;
          st_r <= E_IDLE;
        end
        default: st_r <= E_IDLE;
      endcase
    end
  end
endmodule

// file: verilog/flash_bank_command_decoder.sv
// apb controlled command sequencer for a dual bank parallel nor flash
// ==========================================================
// Functional notes
// - identify mode held until reset written
// - identify only when no operation is active
// - identify is two unlocks plus bank command
// - program is four writes, last starts it
// - short program mode entered by 20h
// - chip erase is six writes
// - sector erase is six writes with sector
// - further sectors queued within 50 us window
`timescale 1ns/1ps
module flash_bank_command_decoder #(
  parameter int WINDOW_CYC = flash_pkg::WINDOW_CYC,
  parameter int SUSP_CYC = flash_pkg::SUSP_CYC,
  parameter int BA_LSB = 20
) (
  input wire logic clk_sys_i,                       // system clock
  input wire logic rstn_i,                          // sync reset, low
  input wire logic [7:0] paddr_i,                   // apb address
  input wire logic psel_i,                          // apb select
  input wire logic penable_i,                       // apb enable
  input wire logic pwrite_i,                        // apb direction
  input wire logic [31:0] pwdata_i,                 // apb write data
  output logic [31:0] prdata_o,                     // apb read data
  output logic pready_o,                            // apb ready
  output logic pslverr_o,                           // apb error
  output logic [flash_pkg::AW-1:0] fl_addr_o,       // flash address
  output logic [flash_pkg::DW-1:0] fl_dq_o,         // flash data out
  output logic fl_dq_oe_o,                          // flash data enable
  input wire logic [flash_pkg::DW-1:0] fl_dq_i,     // flash data in
  output logic fl_ce_n_o,                           // chip select
  output logic fl_we_n_o,                           // write strobe
  output logic fl_oe_n_o,                           // read strobe
  output logic fl_byte_n_o,                         // low: byte mode
  output logic fl_reset_n_o,                        // hardware reset
  output logic protect_accel_pin_o,                 // request high volt
  input wire logic ready_busy_n_i                   // device ready
);
  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_PWAIT, S_WINDOW, S_SUSPW
  } st_e;
  localparam int AW = flash_pkg::AW;
  localparam int DW = flash_pkg::DW;
  localparam int TW = 16;

  st_e state_r;
  localparam int CTRL_W_L = flash_pkg::CTRL_W;
  flash_pkg::op_e cur_op_r, pend_op_r;
  logic [CTRL_W_L-1:0] ctrl_r;
  logic [AW-1:0] addr_r, bus_addr_r;
  logic [DW-1:0] data_r, rdata_r, bus_wdata_r;
  logic [2:0] step_r;
  logic [TW-1:0] tmr_r;
  logic req_r, bus_wr_r, pend_v_r, done_p_r, err_p_r;
  logic ident_r, bypass_r, secured_r, susp_r, erase_r, sect_r;
  logic from_win_r, errseen_r, done_r, err_r, refused_r;

  flash_bus_if fbus();
  assign fbus.req = req_r;
  assign fbus.wr = bus_wr_r;
  assign fbus.addr = bus_addr_r;
  assign fbus.wdata = bus_wdata_r;
  assign fbus.abort = ~fl_reset_n_o;

  flash_cycle_engine u_eng (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(fbus),
    .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
    .fl_dq_i(fl_dq_i), .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o),
    .fl_oe_n_o(fl_oe_n_o)
  );

  // ==========================================================
  // command sequence tables
  function automatic logic [2:0] seq_last(input flash_pkg::op_e op);
    case (op)
      flash_pkg::OP_IDENT, flash_pkg::OP_SEC_ENTER,
      flash_pkg::OP_BYP_ENTER: seq_last = 3'h2;
      flash_pkg::OP_SEC_EXIT, flash_pkg::OP_PROGRAM: seq_last = 3'h3;
      flash_pkg::OP_BYP_PROG, flash_pkg::OP_BYP_EXIT: seq_last = 3'h1;
      flash_pkg::OP_CHIP, flash_pkg::OP_SECT: seq_last = 3'h5;
      default: seq_last = 3'h0;
    endcase
  endfunction

  function automatic logic [AW+DW-1:0] seq_cycle(
    input flash_pkg::op_e op, input logic [2:0] k, input logic bm,
    input logic [AW-1:0] a, input logic [DW-1:0] d,
    input logic [AW-1:0] ba);
    logic [AW-1:0] u1, u2, ra;
    logic [7:0] rd;
    logic full;
    u1 = bm ? flash_pkg::U1_B : flash_pkg::U1_W;
    u2 = bm ? flash_pkg::U2_B : flash_pkg::U2_W;
    full = 1'b0;
    // unlock pair heads every long sequence
    ra = (k == 3'h1 || k == 3'h4) ? u2 : u1;
    rd = (k == 3'h1 || k == 3'h4) ? flash_pkg::D_UNL2 : flash_pkg::D_UNL1;
    case (op)
      flash_pkg::OP_READ: ra = a;
      flash_pkg::OP_RESET: begin
        ra = a;
        rd = flash_pkg::D_RESET;
      end
      flash_pkg::OP_IDENT: if (k == 3'h2) begin
        ra = ba | u1;
        rd = flash_pkg::D_IDENT;
      end
      flash_pkg::OP_SEC_ENTER: if (k == 3'h2) rd = flash_pkg::D_SECENT;
      flash_pkg::OP_SEC_EXIT: if (k == 3'h2) begin
        rd = flash_pkg::D_IDENT;
      end else if (k == 3'h3) begin
        ra = '0;
        rd = flash_pkg::D_ZERO;
      end
      flash_pkg::OP_PROGRAM: if (k == 3'h2) begin
        rd = flash_pkg::D_PROG;
      end else if (k == 3'h3) begin
        ra = a;
        full = 1'b1;
      end
      flash_pkg::OP_BYP_ENTER: if (k == 3'h2) rd = flash_pkg::D_BYPASS;
      flash_pkg::OP_BYP_PROG: if (k == 3'h0) begin
        ra = ba;
        rd = flash_pkg::D_PROG;
      end else begin
        ra = a;
        full = 1'b1;
      end
      flash_pkg::OP_BYP_EXIT: begin
        ra = ba;
        rd = (k == 3'h0) ? flash_pkg::D_IDENT : flash_pkg::D_ZERO;
      end
      flash_pkg::OP_CHIP, flash_pkg::OP_SECT: if (k == 3'h2) begin
        rd = flash_pkg::D_ERASE;
      end else if (k == 3'h5) begin
        ra = (op == flash_pkg::OP_SECT) ? a : u1;
        rd = (op == flash_pkg::OP_SECT) ? flash_pkg::D_SECT
                                        : flash_pkg::D_CHIP;
      end
      flash_pkg::OP_SECT_ADD: begin
        ra = a;
        rd = flash_pkg::D_SECT;
      end
      flash_pkg::OP_SUSP: begin
        ra = ba;
        rd = flash_pkg::D_SUSP;
      end
      flash_pkg::OP_RESUME: begin
        ra = ba;
        rd = flash_pkg::D_RESUME;
      end
      default: ra = a;
    endcase
    seq_cycle = full ? {ra, d} : {ra, 8'h00, rd};
  endfunction

  // ==========================================================
  // apb decode and command acceptance
  wire apb_acc = psel_i & penable_i & ~pready_o;
  wire wr_en = apb_acc & pwrite_i;
  wire hit_ctrl = paddr_i == flash_pkg::A_CTRL;
  wire hit_addr = paddr_i == flash_pkg::A_ADDR;
  wire hit_data = paddr_i == flash_pkg::A_DATA;
  wire hit_cmd = paddr_i == flash_pkg::A_CMD;
  wire hit_stat = paddr_i == flash_pkg::A_STAT;
  wire hit_rdat = paddr_i == flash_pkg::A_RDAT;
  wire mapped = hit_ctrl | hit_addr | hit_data | hit_cmd | hit_stat
              | hit_rdat;
  wire hwrst = ctrl_r[flash_pkg::C_HWRST];
  wire accel = ctrl_r[flash_pkg::C_ACCEL];
  wire flash_pkg::op_e cmd_op = flash_pkg::op_e'(pwdata_i[3:0]);
  wire cmd_wr = wr_en & hit_cmd;
  wire normal = ~bypass_r & ~ident_r;
  wire in_win = state_r == S_WINDOW;
  wire in_spoll = (state_r == S_POLL || state_r == S_PWAIT) & sect_r
                & erase_r;
  wire [AW-1:0] ba_w = {addr_r[AW-1:BA_LSB], {BA_LSB{1'b0}}};
  wire [AW+DW-1:0] cyc_w = seq_cycle(cur_op_r, step_r,
                              ctrl_r[flash_pkg::C_BYTE], addr_r, data_r,
                              ba_w);
  wire tgt_w = erase_r | data_r[flash_pkg::DQ_POLL];
  logic legal_w;
  always_comb begin
    case (cmd_op)
      flash_pkg::OP_READ, flash_pkg::OP_RESET: legal_w = 1'b1;
      flash_pkg::OP_IDENT, flash_pkg::OP_SEC_ENTER,
      flash_pkg::OP_SEC_EXIT, flash_pkg::OP_PROGRAM: legal_w = normal;
      flash_pkg::OP_BYP_PROG: legal_w = (bypass_r | accel) & ~ident_r;
      flash_pkg::OP_BYP_EXIT: legal_w = bypass_r;
      flash_pkg::OP_BYP_ENTER, flash_pkg::OP_CHIP,
      flash_pkg::OP_SECT: legal_w = normal & ~susp_r;
      flash_pkg::OP_RESUME: legal_w = susp_r & ~ident_r;
      default: legal_w = 1'b0;
    endcase
  end
  // identify and new sequences only start from idle, except queued sector add and suspend
  wire idle_ok = (state_r == S_IDLE) & legal_w;
  wire busy_ok = ~pend_v_r & ((in_win & (cmd_op == flash_pkg::OP_SECT_ADD
               | cmd_op == flash_pkg::OP_SUSP))
               | (in_spoll & cmd_op == flash_pkg::OP_SUSP));
  wire cmd_take = cmd_wr & ~hwrst & (idle_ok | busy_ok);
  wire [31:0] stat_w = 32'({ready_busy_n_i, in_win, susp_r, secured_r,
                            bypass_r, ident_r, refused_r, err_r, done_r,
                            state_r != S_IDLE});
  wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_r) : hit_addr ? 32'(addr_r)
                     : hit_data ? 32'(data_r) : hit_stat ? stat_w
                     : hit_rdat ? 32'(rdata_r) : 32'h00000000;
  wire stat_wr = wr_en & hit_stat;

  // ==========================================================
  // register file
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      ctrl_r <= flash_pkg::CTRL_RST;
      addr_r <= '0;
      data_r <= '0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      refused_r <= 1'b0;
      fl_byte_n_o <= 1'b1;
      fl_reset_n_o <= 1'b1;
      protect_accel_pin_o <= 1'b0;
    end else begin
      pready_o <= apb_acc;
      pslverr_o <= apb_acc & ~mapped;
      if (apb_acc & ~pwrite_i) prdata_o <= rd_mux;
      if (wr_en & hit_ctrl) ctrl_r <= pwdata_i[CTRL_W_L-1:0];
      if (wr_en & hit_addr) addr_r <= pwdata_i[AW-1:0];
      if (wr_en & hit_data) data_r <= pwdata_i[DW-1:0];
      // a set in the clearing cycle wins
      done_r <= done_p_r
              | (done_r & ~(stat_wr & pwdata_i[flash_pkg::ST_DONE]));
      err_r <= err_p_r | (err_r & ~(stat_wr & pwdata_i[flash_pkg::ST_ERR]));
      refused_r <= (cmd_wr & ~cmd_take)
                 | (refused_r & ~(stat_wr & pwdata_i[flash_pkg::ST_REFUSED]));
      fl_byte_n_o <= ~ctrl_r[flash_pkg::C_BYTE];
      fl_reset_n_o <= ~hwrst;
      protect_accel_pin_o <= accel;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || hwrst) begin
      // hardware reset is the only abort of a running operation
      state_r <= S_IDLE;
      cur_op_r <= flash_pkg::OP_READ;
      pend_op_r <= flash_pkg::OP_READ;
      {req_r, bus_wr_r, pend_v_r, done_p_r, err_p_r} <= 5'h00;
      {ident_r, bypass_r, secured_r, susp_r, erase_r, sect_r} <= 6'h00;
      {from_win_r, errseen_r} <= 2'h0;
      step_r <= 3'h0;
      tmr_r <= '0;
      bus_addr_r <= '0;
      bus_wdata_r <= '0;
      rdata_r <= '0;
    end else begin
      req_r <= 1'b0;
      done_p_r <= 1'b0;
      err_p_r <= 1'b0;
      if (cmd_take & ~idle_ok) begin
        pend_v_r <= 1'b1;
        pend_op_r <= cmd_op;
      end
      case (state_r)
        S_IDLE: if (cmd_take) begin
          cur_op_r <= cmd_op;
          step_r <= 3'h0;
          state_r <= S_ISSUE;
        end
        S_ISSUE: begin
          req_r <= 1'b1;
          bus_wr_r <= cur_op_r != flash_pkg::OP_READ;
          {bus_addr_r, bus_wdata_r} <= cyc_w;
          state_r <= S_WAIT;
        end
        S_WAIT: if (fbus.ack) begin
          if (step_r != seq_last(cur_op_r)) begin
            step_r <= step_r + 3'h1;
            state_r <= S_ISSUE;
          end else begin
            state_r <= S_IDLE;
            done_p_r <= 1'b1;
            case (cur_op_r)
              flash_pkg::OP_READ: rdata_r <= fbus.rdata;
              flash_pkg::OP_RESET: {ident_r, bypass_r} <= 2'h0;
              flash_pkg::OP_IDENT: ident_r <= 1'b1;
              flash_pkg::OP_SEC_ENTER: secured_r <= 1'b1;
              flash_pkg::OP_SEC_EXIT: secured_r <= 1'b0;
              flash_pkg::OP_BYP_ENTER: bypass_r <= 1'b1;
              flash_pkg::OP_BYP_EXIT: bypass_r <= 1'b0;
              flash_pkg::OP_PROGRAM, flash_pkg::OP_BYP_PROG,
              flash_pkg::OP_CHIP, flash_pkg::OP_RESUME: begin
                done_p_r <= 1'b0;
                erase_r <= cur_op_r == flash_pkg::OP_CHIP
                         || cur_op_r == flash_pkg::OP_RESUME;
                sect_r <= cur_op_r == flash_pkg::OP_RESUME;
                if (cur_op_r == flash_pkg::OP_RESUME) susp_r <= 1'b0;
                state_r <= S_POLL;
              end
              flash_pkg::OP_SECT, flash_pkg::OP_SECT_ADD: begin
                // window timed from the acknowledge of the last write cycle
                done_p_r <= 1'b0;
                {erase_r, sect_r} <= 2'h3;
                tmr_r <= TW'(WINDOW_CYC - 1);
                state_r <= S_WINDOW;
              end
              flash_pkg::OP_SUSP: if (!from_win_r) begin
                done_p_r <= 1'b0;
                tmr_r <= TW'(SUSP_CYC - 1);
                state_r <= S_SUSPW;
              end else begin
                susp_r <= 1'b1;
              end
              default: state_r <= S_IDLE;
            endcase
          end
        end
        S_WINDOW: if (pend_v_r) begin
          // only queued sectors or suspend enter the window
          pend_v_r <= 1'b0;
          cur_op_r <= pend_op_r;
          step_r <= 3'h0;
          from_win_r <= 1'b1;
          state_r <= S_ISSUE;
        end else if (tmr_r == '0) begin
          state_r <= S_POLL;
        end else begin
          tmr_r <= tmr_r - TW'(1);
        end
        S_POLL: if (pend_v_r) begin
          pend_v_r <= 1'b0;
          cur_op_r <= pend_op_r;
          step_r <= 3'h0;
          from_win_r <= 1'b0;
          state_r <= S_ISSUE;
        end else begin
          req_r <= 1'b1;
          bus_wr_r <= 1'b0;
          bus_addr_r <= addr_r;
          state_r <= S_PWAIT;
        end
        S_PWAIT: if (fbus.ack) begin
          if (fbus.rdata[flash_pkg::DQ_POLL] == tgt_w) begin
            errseen_r <= 1'b0;
            done_p_r <= 1'b1;
            state_r <= S_IDLE;
          end else if (fbus.rdata[flash_pkg::DQ_ERR] && errseen_r) begin
            // failed or 0 to 1 attempt: reset write recovers
            errseen_r <= 1'b0;
            err_p_r <= 1'b1;
            cur_op_r <= flash_pkg::OP_RESET;
            step_r <= 3'h0;
            state_r <= S_ISSUE;
          end else begin
            // error flag needs one more read to confirm
            errseen_r <= fbus.rdata[flash_pkg::DQ_ERR];
            state_r <= S_POLL;
          end
        end
        S_SUSPW: if (tmr_r == '0) begin
          susp_r <= 1'b1;
          done_p_r <= 1'b1;
          state_r <= S_IDLE;
        end else begin
          tmr_r <= tmr_r - TW'(1);
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

// file: bench/flash_model.sv
// behavioural flash device standing on the far side of the controller
`timescale 1ns/1ps
module flash_model #(
  parameter logic [15:0] MAKER = 16'h005A  // arbitrary neutral code
) (
  input wire logic [21:0] addr_i,  // address pins
  input wire logic [15:0] dq_i,    // data from controller
  input wire logic ce_n_i,         // chip select
  input wire logic we_n_i,         // write strobe
  input wire logic oe_n_i,         // read strobe
  output logic [15:0] dq_o,        // data to controller
  output logic ready_busy_n_o      // ready
);
  // ======
  logic [15:0] mem = 16'hFFFF;
  logic [7:0] prev = 8'h00;
  logic ident = 1'b0;
  logic flip = 1'b0;
  // data taken at the rising strobe edge
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (prev == 8'hA0) begin
      mem <= mem & dq_i;
      prev <= 8'h00;
    end else begin
      if ((dq_i[7:0] == 8'h10 || dq_i[7:0] == 8'h30) && prev == 8'h55)
        mem <= 16'hFFFF;
      if (dq_i[7:0] == 8'h90 && prev == 8'h55) ident <= 1'b1;
      if (dq_i[7:0] == 8'hF0) ident <= 1'b0;
      prev <= dq_i[7:0];
    end
  end
  // a released bus changes every read so stale data never passes
  always @(posedge oe_n_i) flip <= ~flip;
  assign dq_o = (oe_n_i || ce_n_i) ? {16{flip}} :
    ident ? (addr_i[7:0] == 8'h00 ? MAKER : 16'h0000) : mem;
  assign ready_busy_n_o = 1'b1;  // completes at once
endmodule

// file: bench/fbcd_sva.sv
// assertion checker for the controller apb and flash pins
`timescale 1ns/1ps
module fbcd_sva (
  input wire logic clk_sys_i,                  // clock
  input wire logic rstn_i,                     // reset
  input wire logic psel_i,                     // select
  input wire logic penable_i,                  // enable
  input wire logic [7:0] paddr_i,              // address
  input wire logic pready_o,                   // ready
  input wire logic pslverr_o,                  // error
  input wire logic [flash_pkg::AW-1:0] fl_addr_o,  // flash address
  input wire logic fl_ce_n_o,                  // chip select
  input wire logic fl_we_n_o,                  // write strobe
  input wire logic fl_oe_n_o,                  // read strobe
  input wire logic fl_dq_oe_o                  // data drive
);
  // ======
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] low_cnt;
  always_ff @(posedge clk_sys_i)
    if (!rstn_i || fl_we_n_o) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  ready_wait_a: assert property (psel_i && penable_i && !pready_o
    |=> pready_o) else $error("ready late");
  ready_once_a: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  err_map_a: assert property (pready_o |-> pslverr_o ==
    (paddr_i > 8'h14 || paddr_i[1:0] != 2'h0)) else $error("bad error");
  we_width_a: assert property ($rose(fl_we_n_o) |->
    low_cnt == flash_pkg::STROBE_CYC) else $error("strobe width");
  ce_after_a: assert property ($rose(fl_we_n_o) |=> fl_ce_n_o)
    else $error("select not released");
  we_in_ce_a: assert property (!fl_we_n_o |->
    !fl_ce_n_o && fl_dq_oe_o) else $error("strobe outside select");
  no_fight_a: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o)
    else $error("bus fight");
  addr_hold_a: assert property (!fl_ce_n_o && $past(!fl_ce_n_o)
    |-> $stable(fl_addr_o)) else $error("address moved");
endmodule
bind flash_bank_command_decoder fbcd_sva u_sva (.clk_sys_i, .rstn_i,
  .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .fl_addr_o,
  .fl_ce_n_o, .fl_we_n_o, .fl_oe_n_o, .fl_dq_oe_o);

// file: bench/testbench.sv
// self-checking bench for the flash command controller
`timescale 1ns/1ps
`define CMP(nm, e, s) begin checks++; if ((e) !== (s)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module testbench;
  // ======
  logic clk_sys_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd = 0;
  logic pready, pslverr, ce_n, we_n, oe_n, dq_oe, rb_n, byte_n, rst_n, acc;
  logic [21:0] fa;
  logic [15:0] dq_o, dq_i, d1, d2, d3;
  logic [33:0] notes[$], n;
  int error_cnt = 0, checks = 0, seed = 32'hB7EC;
  localparam logic [15:0] MAKER = 16'h005A;  // arbitrary neutral code
  initial forever #2 clk_sys_i = ~clk_sys_i;
  flash_bank_command_decoder #(.WINDOW_CYC(40), .SUSP_CYC(20)) uut (
    .clk_sys_i, .rstn_i, .paddr_i(paddr), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .fl_addr_o(fa), .fl_dq_o(dq_o), .fl_dq_oe_o(dq_oe),
    .fl_dq_i(dq_i), .fl_ce_n_o(ce_n), .fl_we_n_o(we_n), .fl_oe_n_o(oe_n),
    .fl_byte_n_o(byte_n), .fl_reset_n_o(rst_n), .protect_accel_pin_o(acc),
    .ready_busy_n_i(rb_n));
  flash_model #(.MAKER(MAKER)) fm (.addr_i(fa), .dq_i(dq_o), .ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .dq_o(dq_i), .ready_busy_n_o(rb_n));
  task close_out;
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // note layout: check flag, expected error, expected data
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [33:0] e);
    int i;
    if (!w) notes.push_back(e);
    @(posedge clk_sys_i);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1;
    i = 0;
    do begin @(posedge clk_sys_i); i++; end while (!pready && i < 50);
    if (pready !== 1'b1) begin error_cnt++; close_out; end
    rd = prdata;
    psel <= 0; pen <= 0;
  endtask
  // b: status bit that marks the end of the wait
  task op(input flash_pkg::op_e c, input int b = flash_pkg::ST_DONE);
    int i;
    apb(1, flash_pkg::A_CMD, {28'h0, c}, 0);
    i = 0;
    do begin apb(0, flash_pkg::A_STAT, 0, 0); i++; end
    while (rd[b] !== 1'b1 && i < 400);
    if (i >= 400) begin error_cnt++; close_out; end
    apb(1, flash_pkg::A_STAT, 32'h2, 0);
  endtask
  task rdat(input logic [15:0] e);
    op(flash_pkg::OP_READ);
    apb(0, flash_pkg::A_RDAT, 0, {2'b10, 16'h0, e});
  endtask
  always @(posedge clk_sys_i) if (pready === 1'b1 && !pwr) begin
    n = notes.pop_front();
    if (n[33]) `CMP("prdata", n[32:0], {pslverr, prdata})
  end
  initial begin
    #400000;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1;
    apb(0, flash_pkg::A_STAT, 0, {2'b10, 32'h200});
    apb(0, 8'h18, 0, {2'b11, 32'h0});
    op(flash_pkg::OP_CHIP);
    d1 = $random(seed); d2 = $random(seed); d3 = $random(seed);
    d2[7] = d1[7]; d3[7] = d1[7];
    apb(1, flash_pkg::A_ADDR, {12'h0, 20'($random(seed))}, 0);
    apb(1, flash_pkg::A_DATA, {16'h0, d1}, 0);
    op(flash_pkg::OP_PROGRAM);
    rdat(d1);
    apb(1, flash_pkg::A_DATA, {16'h0, d2}, 0);
    op(flash_pkg::OP_PROGRAM);
    rdat(d1 & d2);
    apb(1, flash_pkg::A_ADDR, 0, 0);
    op(flash_pkg::OP_IDENT);
    rdat(MAKER);
    op(flash_pkg::OP_RESET);
    rdat(d1 & d2);
    apb(1, flash_pkg::A_CMD, {28'h0, flash_pkg::OP_BYP_EXIT}, 0);
    apb(0, flash_pkg::A_STAT, 0, {2'b10, 32'h208});
    apb(1, flash_pkg::A_STAT, 32'h8, 0);
    op(flash_pkg::OP_BYP_ENTER);
    apb(1, flash_pkg::A_DATA, {16'h0, d3}, 0);
    op(flash_pkg::OP_BYP_PROG);
    op(flash_pkg::OP_BYP_EXIT);
    rdat(d1 & d2 & d3);
    // window bit 8 must be seen before each queued command
    op(flash_pkg::OP_SECT, 8);
    op(flash_pkg::OP_SECT_ADD, 8);
    op(flash_pkg::OP_SUSP);
    apb(0, flash_pkg::A_STAT, 0, {2'b10, 32'h280});
    op(flash_pkg::OP_RESUME);
    rdat(16'hFFFF);
    apb(1, flash_pkg::A_CTRL, 32'h7, 0);
    apb(0, flash_pkg::A_CTRL, 0, {2'b10, 32'h7});
    `CMP("pins", 3'b001, {byte_n, rst_n, acc});
    apb(1, flash_pkg::A_CMD, {28'h0, flash_pkg::OP_READ}, 0);
    apb(0, flash_pkg::A_STAT, 0, {2'b10, 32'h208});
    apb(1, flash_pkg::A_CTRL, 0, 0);
    close_out;
  end
endmodule
